// file: rtl/t2_timer.sv
// timer2 capture/reload/baud block with timer1 modes 2 and 3
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "t2_regs.svh"
module t2_timer
  import t2_pkg::*;
#(
  parameter int TICK_DIV = `T2_TICK_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic event_count_input,
  input wire logic capture_reload_trigger,
  output logic uart_rx_clk_pulse,
  output logic uart_tx_clk_pulse,
  output logic timer1_overflow_pulse,
  output logic timer2_irq_req,
  output logic timer2_irq_high_priority,
  output logic [7:0] timer2_irq_vector,
  output logic [3:0] timer2_natural_priority
);

  // the prescaler counter is eight bits wide
  if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_div
    $error("TICK_DIV must lie in 1..256");
  end

  // word-aligned index match, shared by every decode
  function automatic logic hit(
    input logic [9:0] addr,
    input logic [7:0] idx
  );
    return (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // timer2 mode from run, uart selects and capture select
  function automatic t2_mode_t t2_decode(
    input logic run,
    input logic baud,
    input logic cprl
  );
    t2_mode_t m;
    if (!run) begin
      m = T2M_OFF;
    end else if (baud) begin
      m = T2M_BAUD;
    end else if (cprl) begin
      m = T2M_CAPTURE;
    end else begin
      m = T2M_RELOAD;
    end
    return m;
  endfunction

  logic [7:0] pre_cnt;
  logic tick;
  logic [2:0] ev_sync;
  logic [2:0] tr_sync;
  logic ev_fall;
  logic tr_fall;
  logic ack;
  logic req;
  logic wr_go;
  logic [7:0] wd;
  logic [7:0] rd_byte;
  logic [7:0] ie_r;
  logic [7:0] prio_r;
  logic [7:0] tmod_r;
  logic [7:0] t1_lo;
  logic [7:0] t1_hi;
  logic t1_flag;
  logic t1_go;
  logic t1_run;
  logic t1_ovf;
  t2_t1_mode_t t1_mode;
  logic ovf_flag;
  logic trg_flag;
  logic [5:0] t2_cfg;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic [15:0] next_cnt;
  logic baud;
  t2_mode_t t2_mode;
  logic t2_tick;
  logic t2_ovf;
  logic trig;
  logic cap;

  // internal count tick as a one-cycle enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (pre_cnt == 8'(TICK_DIV - 1)) begin
      pre_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // pin synchronisers; reset high so idle pins give no false fall
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_sync <= 3'h7;
      tr_sync <= 3'h7;
    end else begin
      ev_sync <= {ev_sync[1:0], event_count_input};
      tr_sync <= {tr_sync[1:0], capture_reload_trigger};
    end
  end

  // stage 0 is left to stage 1 only; falls compare stages 1 and 2
  assign ev_fall = ev_sync[2] & ~ev_sync[1];
  assign tr_fall = tr_sync[2] & ~tr_sync[1];

  // one wait cycle per access, readdata latched on the first
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_go = avs_write & ack & avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit(avs_address, `T2_IDX_TCON)) begin
      rd_byte = {t1_flag, t1_go, 6'h00};
    end else if (hit(avs_address, `T2_IDX_TMOD)) begin
      rd_byte = tmod_r;
    end else if (hit(avs_address, `T2_IDX_T1LO)) begin
      rd_byte = t1_lo;
    end else if (hit(avs_address, `T2_IDX_T1HI)) begin
      rd_byte = t1_hi;
    end else if (hit(avs_address, `T2_IDX_IE)) begin
      rd_byte = ie_r;
    end else if (hit(avs_address, `T2_IDX_PRIO)) begin
      rd_byte = prio_r;
    end else if (hit(avs_address, `T2_IDX_CTRL)) begin
      rd_byte = {ovf_flag, trg_flag, t2_cfg};
    end else if (hit(avs_address, `T2_IDX_RLO)) begin
      rd_byte = rld[7:0];
    end else if (hit(avs_address, `T2_IDX_RHI)) begin
      rd_byte = rld[15:8];
    end else if (hit(avs_address, `T2_IDX_CNTL)) begin
      rd_byte = cnt[7:0];
    end else if (hit(avs_address, `T2_IDX_CNTH)) begin
      rd_byte = cnt[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // plain control registers written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ie_r <= `T2_RST_BYTE;
      prio_r <= `T2_RST_BYTE;
      tmod_r <= `T2_RST_BYTE;
      t1_go <= 1'b0;
      t2_cfg <= 6'h00;
    end else if (wr_go) begin
      if (hit(avs_address, `T2_IDX_IE)) begin
        ie_r <= wd & `T2_IE_MASK;
      end
      if (hit(avs_address, `T2_IDX_PRIO)) begin
        prio_r <= wd & `T2_PRIO_MASK;
      end
      if (hit(avs_address, `T2_IDX_TMOD)) begin
        tmod_r <= wd;
      end
      if (hit(avs_address, `T2_IDX_TCON)) begin
        t1_go <= wd[`T2_TCON_RUN];
      end
      if (hit(avs_address, `T2_IDX_CTRL)) begin
        t2_cfg <= wd[5:0];
      end
    end
  end

  // timer1: only the 8-bit reload mode counts in this block
  assign t1_mode = t2_t1_mode_t'(tmod_r[`T2_TMOD_M1:`T2_TMOD_M0]);
  // mode3 falls out here exactly like a cleared run bit
  assign t1_run = t1_go & tick & (t1_mode == T1M_RELOAD8);
  assign t1_ovf = t1_run & (t1_lo == 8'hff);

  // software byte write beats the count in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_lo <= `T2_RST_BYTE;
    end else if (wr_go && hit(avs_address, `T2_IDX_T1LO)) begin
      t1_lo <= wd;
    end else if (t1_ovf) begin
      t1_lo <= t1_hi;
    end else if (t1_run) begin
      t1_lo <= t1_lo + 8'h01;
    end
  end

  // high byte is only ever changed by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_hi <= `T2_RST_BYTE;
    end else if (wr_go && hit(avs_address, `T2_IDX_T1HI)) begin
      t1_hi <= wd;
    end
  end

  // timer1 flag: a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t1_flag <= 1'b0;
    end else if (t1_ovf) begin
      t1_flag <= 1'b1;
    end else if (wr_go && hit(avs_address, `T2_IDX_TCON)) begin
      t1_flag <= wd[`T2_TCON_OVF];
    end
  end

  // timer2 mode and count enable
  assign baud = t2_cfg[`T2_CON_RXSEL] | t2_cfg[`T2_CON_TXSEL];
  assign t2_mode = t2_decode(t2_cfg[`T2_CON_RUN], baud,
                             t2_cfg[`T2_CON_CAPSEL]);
  assign t2_tick = (t2_mode != T2M_OFF) &
                   (t2_cfg[`T2_CON_CSEL] ? ev_fall : tick);
  assign t2_ovf = t2_tick & (cnt == 16'hffff);
  assign trig = tr_fall & t2_cfg[`T2_CON_TRGEN];
  assign cap = trig & (t2_mode == T2M_CAPTURE);

  // next count from the mode
  always_comb begin
    next_cnt = cnt;
    unique case (t2_mode)
      T2M_OFF: begin
        next_cnt = cnt;
      end
      T2M_RELOAD: begin
        if (t2_ovf | trig) begin
          next_cnt = rld;
        end else if (t2_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end
      T2M_CAPTURE: begin
        // plain 16-bit wrap, the pair only takes captures
        if (t2_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end
      T2M_BAUD: begin
        // trigger edges never reload here, only overflow does
        if (t2_ovf) begin
          next_cnt = rld;
        end else if (t2_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end
    endcase
  end

  // count register; a software byte write overrides that byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= `T2_RST_CNT;
    end else begin
      cnt <= next_cnt;
      if (wr_go && hit(avs_address, `T2_IDX_CNTL)) begin
        cnt[7:0] <= wd;
      end
      if (wr_go && hit(avs_address, `T2_IDX_CNTH)) begin
        cnt[15:8] <= wd;
      end
    end
  end

  // reload pair; a capture beats a software write so no edge is lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rld <= `T2_RST_CNT;
    end else if (cap) begin
      rld <= cnt;
    end else if (wr_go) begin
      if (hit(avs_address, `T2_IDX_RLO)) begin
        rld[7:0] <= wd;
      end
      if (hit(avs_address, `T2_IDX_RHI)) begin
        rld[15:8] <= wd;
      end
    end
  end

  // overflow flag: set wins over clear, never set in baud mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovf_flag <= 1'b0;
    end else if (t2_ovf & ~baud) begin
      ovf_flag <= 1'b1;
    end else if (wr_go && hit(avs_address, `T2_IDX_CTRL)) begin
      ovf_flag <= wd[`T2_CON_OVF];
    end
  end

  // trigger flag works in every mode and is cleared only by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trg_flag <= 1'b0;
    end else if (trig) begin
      trg_flag <= 1'b1;
    end else if (wr_go && hit(avs_address, `T2_IDX_CTRL)) begin
      trg_flag <= wd[`T2_CON_TRGF];
    end
  end

  // uart bit clocks and the timer1 overflow strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uart_rx_clk_pulse <= 1'b0;
      uart_tx_clk_pulse <= 1'b0;
      timer1_overflow_pulse <= 1'b0;
    end else begin
      uart_rx_clk_pulse <= t2_cfg[`T2_CON_RXSEL] ? t2_ovf : t1_ovf;
      uart_tx_clk_pulse <= t2_cfg[`T2_CON_TXSEL] ? t2_ovf : t1_ovf;
      timer1_overflow_pulse <= t1_ovf;
    end
  end

  // interrupt request level; nothing here clears a flag on entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer2_irq_req <= 1'b0;
    end else begin
      timer2_irq_req <= (ovf_flag | trg_flag) & ie_r[`T2_IE_OWN] &
                        ie_r[`T2_IE_ALL];
    end
  end

  // priority level and fixed delivery figures
  assign timer2_irq_high_priority = prio_r[`T2_PRIO_HI];
  assign timer2_irq_vector = `T2_VECTOR;
  assign timer2_natural_priority = `T2_NAT_PRIO;

endmodule

// file: rtl/t2_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef T2_REGS_SVH
`define T2_REGS_SVH

// register indices; byte address on the bus is four times the index
`define T2_IDX_TCON 8'h88
`define T2_IDX_TMOD 8'h89
`define T2_IDX_T1LO 8'h8b
`define T2_IDX_T1HI 8'h8d
`define T2_IDX_IE 8'ha8
`define T2_IDX_PRIO 8'hb8
`define T2_IDX_CTRL 8'hc8
`define T2_IDX_RLO 8'hca
`define T2_IDX_RHI 8'hcb
`define T2_IDX_CNTL 8'hcc
`define T2_IDX_CNTH 8'hcd

// timer2_control fields
`define T2_CON_OVF 7
`define T2_CON_TRGF 6
`define T2_CON_RXSEL 5
`define T2_CON_TXSEL 4
`define T2_CON_TRGEN 3
`define T2_CON_RUN 2
`define T2_CON_CSEL 1
`define T2_CON_CAPSEL 0

// timer1 fields in the timer configuration and mode registers
`define T2_TCON_OVF 7
`define T2_TCON_RUN 6
`define T2_TMOD_M1 5
`define T2_TMOD_M0 4

// interrupt enable and priority fields
`define T2_IE_ALL 7
`define T2_IE_OWN 5
`define T2_PRIO_HI 5
`define T2_IE_MASK 8'hbf
`define T2_PRIO_MASK 8'h3f

// reset values
`define T2_RST_BYTE 8'h00
`define T2_RST_CNT 16'h0000

// internal count tick: one per this many system clocks
`define T2_TICK_DIV 12
// interrupt delivery figures
`define T2_VECTOR 8'h2b
`define T2_NAT_PRIO 4'h6

`endif

// file: rtl/t2_pkg.sv
// types shared by the timer2 block
package t2_pkg;

  // timer2 operating mode, decoded from control bits
  typedef enum logic [1:0] {
    T2M_OFF,
    T2M_RELOAD,
    T2M_CAPTURE,
    T2M_BAUD
  } t2_mode_t;

  // timer1 mode field
  typedef enum logic [1:0] {
    T1M_13BIT,
    T1M_16BIT,
    T1M_RELOAD8,
    T1M_HOLD
  } t2_t1_mode_t;

endpackage

// file: test/t2_pin_model.sv
// pulse source standing in for the event and trigger pins
`timescale 1ns/1ps
module t2_pin_model (
  input wire logic clk,
  input wire logic ev_go,
  input wire logic tr_go,
  output logic ev_pin,
  output logic tr_pin
);
  logic [1:0] ev_n = 2'h0;
  logic [1:0] tr_n = 2'h0;
  // each request holds the pin low three clocks, above the two needed
  always @(posedge clk) begin
    ev_n <= ev_go ? 2'h3 : ev_n - {1'b0, ev_n != 2'h0};
    tr_n <= tr_go ? 2'h3 : tr_n - {1'b0, tr_n != 2'h0};
  end
  // idle high so a sampled fall only comes from a request
  assign ev_pin = ev_n == 2'h0;
  assign tr_pin = tr_n == 2'h0;
endmodule

// file: test/t2_timer_checker.sv
// port-level assertions for the timer2 block
`timescale 1ns/1ps
`include "t2_regs.svh"
module t2_timer_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic uart_rx_clk_pulse,
  input wire logic uart_tx_clk_pulse,
  input wire logic timer1_overflow_pulse,
  input wire logic timer2_irq_req,
  input wire logic timer2_irq_high_priority,
  input wire logic [7:0] timer2_irq_vector,
  input wire logic [3:0] timer2_natural_priority
);
  logic [7:0] ie_q;
  logic [7:0] prio_q;
  logic [7:0] con_q;
  logic ie_ok;
  logic req;
  logic wdone;
  assign req = avs_read | avs_write;
  assign wdone = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign ie_ok = ie_q[7] & ie_q[5];
  // shadow of the bytes software wrote, no hardware bits in them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ie_q <= 8'h00;
      prio_q <= 8'h00;
      con_q <= 8'h00;
    end else if (wdone && avs_address[1:0] == 2'h0) begin
      if (avs_address[9:2] == `T2_IDX_IE) ie_q <= avs_writedata[7:0];
      if (avs_address[9:2] == `T2_IDX_PRIO) prio_q <= avs_writedata[7:0];
      if (avs_address[9:2] == `T2_IDX_CTRL) con_q <= avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_vector_fixed: assert property (timer2_irq_vector == 8'h2b &&
    timer2_natural_priority == 4'h6) else $error("vector or priority");
  a_t1_single: assert property (timer1_overflow_pulse |=>
    !timer1_overflow_pulse) else $error("timer1 pulse too long");
  a_irq_gated: assert property (timer2_irq_req |-> $past(ie_ok))
    else $error("irq without both enables");
  a_prio_bit: assert property (timer2_irq_high_priority == prio_q[5])
    else $error("priority level wrong");
  a_rx_timer1: assert property (!con_q[5] && !$past(con_q[5]) |->
    uart_rx_clk_pulse == timer1_overflow_pulse) else $error("rx source");
  a_tx_timer1: assert property (!con_q[4] && !$past(con_q[4]) |->
    uart_tx_clk_pulse == timer1_overflow_pulse) else $error("tx source");
  c_irq: cover property (timer2_irq_req);
  c_tx: cover property (uart_tx_clk_pulse && con_q[4]);
  c_t1: cover property (timer1_overflow_pulse);
endmodule

bind t2_timer t2_timer_checker u_t2_timer_checker (.clk(clk),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .uart_rx_clk_pulse(uart_rx_clk_pulse),
  .uart_tx_clk_pulse(uart_tx_clk_pulse),
  .timer1_overflow_pulse(timer1_overflow_pulse),
  .timer2_irq_req(timer2_irq_req),
  .timer2_irq_high_priority(timer2_irq_high_priority),
  .timer2_irq_vector(timer2_irq_vector),
  .timer2_natural_priority(timer2_natural_priority));

// file: test/t2_timer_tb.sv
// self-checking bench for the timer2 block
`timescale 1ns/1ps
`include "t2_regs.svh"
module t2_timer_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, ev_pin, tr_pin, rx_p, tx_p, t1_p, irq, hp;
  logic ev_go = 1'b0;
  logic tr_go = 1'b0;
  logic [7:0] vec;
  logic [3:0] nprio;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] q;
  // short tick keeps each overflow within a few dozen clocks
  t2_timer #(.TICK_DIV(2)) u_t2_timer (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_count_input(ev_pin),
    .capture_reload_trigger(tr_pin), .uart_rx_clk_pulse(rx_p),
    .uart_tx_clk_pulse(tx_p), .timer1_overflow_pulse(t1_p),
    .timer2_irq_req(irq), .timer2_irq_high_priority(hp),
    .timer2_irq_vector(vec), .timer2_natural_priority(nprio));
  t2_pin_model u_t2_pin_model (.clk(clk), .ev_go(ev_go), .tr_go(tr_go),
    .ev_pin(ev_pin), .tr_pin(tr_pin));
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bus access: held until wait drops, released after that edge
  task automatic bus(input logic wr, input logic [7:0] i,
    input logic [7:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bw(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    ck({24'h0, q}, {24'h0, e});
  endtask
  // pin fall, then the sync and detect delay plus margin
  task automatic pin(input logic trg);
    if (trg) tr_go <= 1'b1;
    else ev_go <= 1'b1;
    @(posedge clk);
    tr_go <= 1'b0;
    ev_go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic hit(input int k);
    int n;
    n = 0;
    while (n < 300 && !(k == 0 ? t1_p === 1'b1 :
      k == 1 ? tx_p === 1'b1 : k == 2 ? irq === 1'b1 :
      rx_p === 1'b1)) begin
      @(negedge clk);
      n++;
    end
    ck({31'h0, n < 300}, 32'h1);
    @(posedge clk);
  endtask
  task automatic t_misc();
    rc(`T2_IDX_CTRL, 8'h00);
    rc(`T2_IDX_PRIO, 8'h00);
    rc(8'h00, 8'h00);
    bw(`T2_IDX_PRIO, 8'h20);
    rc(`T2_IDX_PRIO, 8'h20);
    ck({31'h0, hp}, 32'h1);
    ck({20'h0, nprio, vec}, 32'h62b);
    $display("misc done");
  endtask
  task automatic t_reload();
    bw(`T2_IDX_IE, 8'ha0);
    bw(`T2_IDX_RLO, 8'hf0);
    bw(`T2_IDX_RHI, 8'hff);
    bw(`T2_IDX_CNTL, 8'hf0);
    bw(`T2_IDX_CNTH, 8'hff);
    repeat (20) @(posedge clk);
    rc(`T2_IDX_CNTL, 8'hf0);
    bw(`T2_IDX_CTRL, 8'h04);
    hit(2);
    repeat (10) @(posedge clk);
    rc(`T2_IDX_CTRL, 8'h84);
    rc(`T2_IDX_CNTH, 8'hff);
    // second clear covers an overflow landing on the first one
    repeat (2) bw(`T2_IDX_CTRL, 8'h00);
    @(negedge clk);
    ck({31'h0, irq}, 32'h0);
    @(posedge clk);
    bw(`T2_IDX_CTRL, 8'h80);
    repeat (3) @(negedge clk);
    ck({31'h0, irq}, 32'h1);
    @(posedge clk);
    bw(`T2_IDX_CTRL, 8'h00);
    $display("reload done");
  endtask
  task automatic t_baud();
    bw(`T2_IDX_CNTL, 8'hf0);
    bw(`T2_IDX_CNTH, 8'hff);
    bw(`T2_IDX_CTRL, 8'h35);
    hit(1);
    hit(3);
    rc(`T2_IDX_CTRL, 8'h35);
    rc(`T2_IDX_CNTH, 8'hff);
    bw(`T2_IDX_CTRL, 8'h00);
    $display("baud done");
  endtask
  task automatic t_capture();
    bw(`T2_IDX_CNTL, 8'h34);
    bw(`T2_IDX_CNTH, 8'h12);
    bw(`T2_IDX_CTRL, 8'h0f);
    pin(1'b1);
    rc(`T2_IDX_RLO, 8'h34);
    rc(`T2_IDX_RHI, 8'h12);
    rc(`T2_IDX_CTRL, 8'h4f);
    ck({31'h0, irq}, 32'h1);
    repeat (3) pin(1'b0);
    rc(`T2_IDX_CNTL, 8'h37);
    bw(`T2_IDX_CTRL, 8'h06);
    pin(1'b1);
    rc(`T2_IDX_CNTL, 8'h37);
    rc(`T2_IDX_CTRL, 8'h06);
    bw(`T2_IDX_CTRL, 8'h0e);
    pin(1'b1);
    rc(`T2_IDX_CNTH, 8'h12);
    rc(`T2_IDX_CNTL, 8'h34);
    bw(`T2_IDX_CNTL, 8'hff);
    bw(`T2_IDX_CNTH, 8'hff);
    pin(1'b0);
    rc(`T2_IDX_CNTL, 8'h34);
    rc(`T2_IDX_CTRL, 8'hce);
    bw(`T2_IDX_CTRL, 8'h00);
    $display("capture done");
  endtask
  task automatic t_timer1();
    logic [7:0] a;
    bw(`T2_IDX_TMOD, 8'h20);
    bw(`T2_IDX_T1HI, 8'hf0);
    bw(`T2_IDX_T1LO, 8'hf0);
    bw(`T2_IDX_TCON, 8'h40);
    hit(0);
    hit(3);
    rc(`T2_IDX_T1HI, 8'hf0);
    rc(`T2_IDX_TCON, 8'hc0);
    bw(`T2_IDX_TMOD, 8'h30);
    // mode 3 holds the count; reload left it at or above the high byte
    bus(1'b0, `T2_IDX_T1LO, 8'h00);
    a = q;
    ck({31'h0, a >= 8'hf0}, 32'h1);
    repeat (40) @(posedge clk);
    rc(`T2_IDX_T1LO, a);
    $display("timer1 done");
  endtask
  // reset, then scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_misc();
    t_reload();
    t_baud();
    t_capture();
    t_timer1();
    complete_run();
  end
endmodule
